/* src/famsr_pkg.sv */
// Purpose: constants for the alert/fault mask and status register bank
// Assumes: byte-wide registers addressed by command code
// Notes:   command codes are byte addresses on the command port
package famsr_pkg;
  // ----------------------------------------------------------------
  // command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] FAMSR_WARN_MASK_CMD  = 8'hF9;
  localparam logic [7:0] FAMSR_TRIP_MASK_CMD  = 8'hFA;
  localparam logic [7:0] FAMSR_SUMMARY_CMD    = 8'hFB;
  localparam logic [7:0] FAMSR_PHASE_CMD      = 8'hFC;
  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] FAMSR_WARN_MASK_RST  = 8'h00;
  localparam logic [7:0] FAMSR_TRIP_MASK_RST  = 8'h00;
  localparam logic [7:0] FAMSR_UNMAPPED_DATA  = 8'h00;
  // ----------------------------------------------------------------
  // mask bit positions (same layout in both mask registers)
  // ----------------------------------------------------------------
  localparam int FAMSR_MASK_VOUT_BIT = 7;
  localparam int FAMSR_MASK_IOUT_BIT = 6;
  localparam int FAMSR_MASK_COMM_BIT = 3;
  localparam int FAMSR_MASK_MVLT_BIT = 2;
  localparam int FAMSR_MASK_POUT_BIT = 0;
  localparam logic [7:0] FAMSR_MASK_WMASK = 8'hCD;
  // ----------------------------------------------------------------
  // status bit positions
  // ----------------------------------------------------------------
  localparam int FAMSR_SUM_TRIP_BIT  = 7;
  localparam int FAMSR_SUM_WARN_BIT  = 6;
  localparam int FAMSR_SUM_PGOOD_BIT = 5;
  localparam int FAMSR_SUM_RDY_BIT   = 4;
  localparam int FAMSR_PH_P4_BIT     = 5;
  localparam int FAMSR_PH_P3_BIT     = 4;
  localparam int FAMSR_PH_P2_BIT     = 3;
  localparam int FAMSR_PH_PSAV_BIT   = 2;
  // ----------------------------------------------------------------
  // source vector layout
  // ----------------------------------------------------------------
  localparam int FAMSR_SRC_VOUT = 0;
  localparam int FAMSR_SRC_IOUT = 1;
  localparam int FAMSR_SRC_COMM = 2;
  localparam int FAMSR_SRC_MVLT = 3;
  localparam int FAMSR_SRC_POUT = 4;
  localparam int FAMSR_SRC_N    = 5;
endpackage

/* src/famsr_gate.sv */
// Purpose: mask gating of status sources onto one alert line
// Assumes: source flags active high, masks active high
// Notes:   output is a registered active-high summary
`timescale 1ns/1ps
module famsr_gate
  import famsr_pkg::*;
(
  input  wire logic                   clk_sys,
  input  wire logic                   rst_n_int,
  input  wire logic [FAMSR_SRC_N-1:0] src_flags,
  input  wire logic [7:0]             mask_reg,
  output logic                        line_active
);
  logic [FAMSR_SRC_N-1:0] mask_vec;
  logic                   line_nxt;

  assign mask_vec[FAMSR_SRC_VOUT] = mask_reg[FAMSR_MASK_VOUT_BIT];
  assign mask_vec[FAMSR_SRC_IOUT] = mask_reg[FAMSR_MASK_IOUT_BIT];
  assign mask_vec[FAMSR_SRC_COMM] = mask_reg[FAMSR_MASK_COMM_BIT];
  assign mask_vec[FAMSR_SRC_MVLT] = mask_reg[FAMSR_MASK_MVLT_BIT];
  assign mask_vec[FAMSR_SRC_POUT] = mask_reg[FAMSR_MASK_POUT_BIT];
  assign line_nxt = |(src_flags & ~mask_vec);

  always_ff @(posedge clk_sys or negedge rst_n_int) begin
    if (!rst_n_int) begin
      line_active <= 1'b0;
    end else begin
      line_active <= line_nxt;
    end
  end
endmodule

/* src/famsr_top.sv */
// Purpose: warning/trip mask registers, summary and phase status bytes
// Assumes: command port is a byte-wide strobe interface behind the serial front end
// Notes:   warning and trip pins are open drain, oe low means pulling the pin low
`timescale 1ns/1ps
// Functional notes
// - warning mask bit 3 blocks comm/logic status from the warning output
// - warning mask bit 2 blocks monitored voltage limit crossings from warning
// - warning mask bit 0 blocks output power excess from warning
// - trip mask bits 7, 6, 3 block vout, iout, comm/logic from trip
// - trip mask bit 0 blocks output power excess from trip
// - summary bit 5 is obsolete; power good lives in status word bit 3
// - phase status bit 5 reads one while phase four is enabled
// - phase status bit 4 reads one while phase three is enabled
// - phase status bit 3 reads one while phase two is enabled
// - phase status bit 2 follows the power-save input
// - warning mask bits 7, 6 block vout and iout status from warning
module famsr_top
  import famsr_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       rst_b,
  input  wire logic       cmd_wr,
  input  wire logic       cmd_rd,
  input  wire logic [7:0] cmd_code,
  input  wire logic [7:0] cmd_wdata,
  output logic [7:0]      cmd_rdata,
  output logic            cmd_rvalid,
  input  wire logic       vout_status_any,
  input  wire logic       iout_status_any,
  input  wire logic       comm_logic_status,
  input  wire logic       monitored_voltage,
  input  wire logic       pout_over_limit,
  input  wire logic       device_ready,
  input  wire logic       supply_ok_flag,
  input  wire logic       phase2_enabled,
  input  wire logic       phase3_enabled,
  input  wire logic       phase4_enabled,
  input  wire logic       power_save_input,
  output logic            warning_pin_o,
  output logic            warning_pin_oe_b,
  output logic            trip_pin_o,
  output logic            trip_pin_oe_b,
  output logic [7:0]      warning_mask_out,
  output logic [7:0]      trip_mask_out
);
  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic rst_meta_r;
  logic rst_n_int;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_r <= 1'b0;
      rst_n_int  <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_int  <= rst_meta_r;
    end
  end

  // ----------------------------------------------------------------
  // mask registers
  // ----------------------------------------------------------------
  logic [7:0] warning_output_mask_r;
  logic [7:0] trip_output_mask_r;
  logic       wr_warn;
  logic       wr_trip;

  // summary and phase bytes are read only, so writes to them fall through
  assign wr_warn = cmd_wr && (cmd_code == FAMSR_WARN_MASK_CMD);
  assign wr_trip = cmd_wr && (cmd_code == FAMSR_TRIP_MASK_CMD);

  // reserved mask bits stay zero so they read back as zero
  always_ff @(posedge clk_sys or negedge rst_n_int) begin
    if (!rst_n_int) begin
      warning_output_mask_r <= FAMSR_WARN_MASK_RST;
      trip_output_mask_r    <= FAMSR_TRIP_MASK_RST;
    end else begin
      if (wr_warn) begin
        warning_output_mask_r <= cmd_wdata & FAMSR_MASK_WMASK;
      end
      if (wr_trip) begin
        trip_output_mask_r <= cmd_wdata & FAMSR_MASK_WMASK;
      end
    end
  end

  // ----------------------------------------------------------------
  // gating
  // ----------------------------------------------------------------
  logic [FAMSR_SRC_N-1:0] src_flags;
  logic                   warn_active;
  logic                   trip_active;

  assign src_flags[FAMSR_SRC_VOUT] = vout_status_any;
  assign src_flags[FAMSR_SRC_IOUT] = iout_status_any;
  assign src_flags[FAMSR_SRC_COMM] = comm_logic_status;
  assign src_flags[FAMSR_SRC_MVLT] = monitored_voltage;
  assign src_flags[FAMSR_SRC_POUT] = pout_over_limit;

  // one gate per output; same bit layout so one module serves both
  famsr_gate u_warn_gate (
    .clk_sys     (clk_sys),
    .rst_n_int   (rst_n_int),
    .src_flags   (src_flags),
    .mask_reg    (warning_output_mask_r),
    .line_active (warn_active)
  );

  famsr_gate u_trip_gate (
    .clk_sys     (clk_sys),
    .rst_n_int   (rst_n_int),
    .src_flags   (src_flags),
    .mask_reg    (trip_output_mask_r),
    .line_active (trip_active)
  );

  // ----------------------------------------------------------------
  // status bytes
  // ----------------------------------------------------------------
  logic [7:0] summary_status_byte;
  logic [7:0] active_phase_status;

  // power good bit stays zero; software reads it from the status word
  always_comb begin
    summary_status_byte                      = 8'h00;
    summary_status_byte[FAMSR_SUM_TRIP_BIT]  = trip_active;
    summary_status_byte[FAMSR_SUM_WARN_BIT]  = warn_active;
    summary_status_byte[FAMSR_SUM_PGOOD_BIT] = 1'b0;
    summary_status_byte[FAMSR_SUM_RDY_BIT]   = device_ready;
  end

  always_comb begin
    active_phase_status                   = 8'h00;
    active_phase_status[FAMSR_PH_P4_BIT]  = phase4_enabled;
    active_phase_status[FAMSR_PH_P3_BIT]  = phase3_enabled;
    active_phase_status[FAMSR_PH_P2_BIT]  = phase2_enabled;
    active_phase_status[FAMSR_PH_PSAV_BIT] = power_save_input;
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  logic [7:0] rd_mux;
  logic [7:0] cmd_rdata_r;
  logic       cmd_rvalid_r;

  assign rd_mux = (cmd_code == FAMSR_WARN_MASK_CMD) ? warning_output_mask_r :
                  (cmd_code == FAMSR_TRIP_MASK_CMD) ? trip_output_mask_r :
                  (cmd_code == FAMSR_SUMMARY_CMD)   ? summary_status_byte :
                  (cmd_code == FAMSR_PHASE_CMD)     ? active_phase_status :
                  FAMSR_UNMAPPED_DATA;

  // data is held after the read so a slow serial shifter can pick it up
  always_ff @(posedge clk_sys or negedge rst_n_int) begin
    if (!rst_n_int) begin
      cmd_rdata_r  <= 8'h00;
      cmd_rvalid_r <= 1'b0;
    end else begin
      cmd_rvalid_r <= cmd_rd;
      if (cmd_rd) begin
        cmd_rdata_r <= rd_mux;
      end
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  logic warn_oe_b_r;
  logic trip_oe_b_r;
  logic [7:0] warn_mask_out_r;
  logic [7:0] trip_mask_out_r;

  // open drain: enable low pulls the pin low while the line is active
  always_ff @(posedge clk_sys or negedge rst_n_int) begin
    if (!rst_n_int) begin
      warn_oe_b_r     <= 1'b1;
      trip_oe_b_r     <= 1'b1;
      warn_mask_out_r <= FAMSR_WARN_MASK_RST;
      trip_mask_out_r <= FAMSR_TRIP_MASK_RST;
    end else begin
      warn_oe_b_r     <= ~warn_active;
      trip_oe_b_r     <= ~trip_active;
      warn_mask_out_r <= warning_output_mask_r;
      trip_mask_out_r <= trip_output_mask_r;
    end
  end

  assign cmd_rdata        = cmd_rdata_r;
  assign cmd_rvalid       = cmd_rvalid_r;
  assign warning_pin_o    = 1'b0;
  assign warning_pin_oe_b = warn_oe_b_r;
  assign trip_pin_o       = 1'b0;
  assign trip_pin_oe_b    = trip_oe_b_r;
  assign warning_mask_out = warn_mask_out_r;
  assign trip_mask_out    = trip_mask_out_r;
endmodule

/* dv/famsr_properties.sv */
// Purpose: port-level assertions for the mask and status bank
// Assumes: pins follow a source or mask change two edges later
// Notes:   checks wait until the internal reset copy has long cleared
`timescale 1ns/1ps
module famsr_chk
  import famsr_pkg::*;
(
  input wire logic       clk_sys,
  input wire logic       rst_b,
  input wire logic       cmd_rd,
  input wire logic [7:0] cmd_code,
  input wire logic [7:0] cmd_rdata,
  input wire logic       vout_status_any,
  input wire logic       iout_status_any,
  input wire logic       comm_logic_status,
  input wire logic       monitored_voltage,
  input wire logic       pout_over_limit,
  input wire logic       device_ready,
  input wire logic       phase2_enabled,
  input wire logic       phase3_enabled,
  input wire logic       phase4_enabled,
  input wire logic       power_save_input,
  input wire logic       warning_pin_oe_b,
  input wire logic       trip_pin_oe_b,
  input wire logic [7:0] warning_mask_out,
  input wire logic [7:0] trip_mask_out
);
  logic [2:0] up_r;
  logic [4:0] src;
  assign src = {vout_status_any, iout_status_any, comm_logic_status, monitored_voltage,
                pout_over_limit};
  // the pins lag release by the reset synchroniser plus two stages, so wait
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) up_r <= 3'h0;
    else if (up_r != 3'h6) up_r <= up_r + 3'h1;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (up_r != 3'h6);
  property p_warn_cml;
    $past(src, 2) == 5'h04 |-> warning_pin_oe_b == $past(warning_mask_out[3]);
  endproperty
  a_warn_cml: assert property (p_warn_cml) else $error("warning pin wrong for comm");
  property p_warn_mvlt;
    $past(src, 2) == 5'h02 |-> warning_pin_oe_b == $past(warning_mask_out[2]);
  endproperty
  a_warn_mvlt: assert property (p_warn_mvlt) else $error("warning pin wrong for mvlt");
  property p_warn_pout;
    $past(src, 2) == 5'h01 |-> warning_pin_oe_b == $past(warning_mask_out[0]);
  endproperty
  a_warn_pout: assert property (p_warn_pout) else $error("warning pin wrong for pout");
  property p_warn_vout;
    $past(src, 2) == 5'h10 |-> warning_pin_oe_b == $past(warning_mask_out[7]);
  endproperty
  a_warn_vout: assert property (p_warn_vout) else $error("warning pin wrong for vout");
  property p_trip_iout;
    $past(src, 2) == 5'h08 |-> trip_pin_oe_b == $past(trip_mask_out[6]);
  endproperty
  a_trip_iout: assert property (p_trip_iout) else $error("trip pin wrong for iout");
  property p_trip_vout;
    $past(src, 2) == 5'h10 |-> trip_pin_oe_b == $past(trip_mask_out[7]);
  endproperty
  a_trip_vout: assert property (p_trip_vout) else $error("trip pin wrong for vout");
  property p_trip_comm;
    $past(src, 2) == 5'h04 |-> trip_pin_oe_b == $past(trip_mask_out[3]);
  endproperty
  a_trip_comm: assert property (p_trip_comm) else $error("trip pin wrong for comm");
  property p_trip_pout;
    $past(src, 2) == 5'h01 |-> trip_pin_oe_b == $past(trip_mask_out[0]);
  endproperty
  a_trip_pout: assert property (p_trip_pout) else $error("trip pin wrong for pout");
  property p_trip_mvlt;
    $past(src, 2) == 5'h02 |-> trip_pin_oe_b == $past(trip_mask_out[2]);
  endproperty
  a_trip_mvlt: assert property (p_trip_mvlt) else $error("trip pin wrong for mvlt");
  property p_phase_read;
    cmd_rd && cmd_code == FAMSR_PHASE_CMD |=> cmd_rdata == {2'h0, $past(phase4_enabled),
      $past(phase3_enabled), $past(phase2_enabled), $past(power_save_input), 2'h0};
  endproperty
  a_phase_read: assert property (p_phase_read) else $error("phase byte wrong");
  property p_sum_read;
    cmd_rd && cmd_code == FAMSR_SUMMARY_CMD |=> cmd_rdata[5:4] == {1'h0, $past(device_ready)};
  endproperty
  a_sum_read: assert property (p_sum_read) else $error("summary byte wrong");
endmodule
bind famsr_top famsr_chk u_chk (.*);

/* dv/famsr_host.sv */
// Purpose: host side of the command port, issuing single-byte accesses
// Assumes: one-cycle strobes, read answer one edge later
// Notes:   code is scrambled once any strobe ends, write data only once a write strobe ends
`timescale 1ns/1ps
module famsr_host (
  input  wire logic       clk_sys,
  input  wire logic [7:0] cmd_rdata,
  input  wire logic       cmd_rvalid,
  output logic            cmd_wr,
  output logic            cmd_rd,
  output logic [7:0]      cmd_code,
  output logic [7:0]      cmd_wdata
);
  initial begin
    cmd_wr = 1'h0;
    cmd_rd = 1'h0;
    cmd_code = 8'h00;
    cmd_wdata = 8'h00;
  end
  task automatic wr(input logic [7:0] code, input logic [7:0] data);
    @(posedge clk_sys);
    #1 {cmd_wr, cmd_code, cmd_wdata} = {1'h1, code, data};
    @(posedge clk_sys);
    #1 {cmd_wr, cmd_code, cmd_wdata} = {1'h0, ~code, ~data};
  endtask
  task automatic rd(input logic [7:0] code, output logic [7:0] data, output logic ok);
    int n;
    @(posedge clk_sys);
    #1 {cmd_rd, cmd_code} = {1'h1, code};
    @(posedge clk_sys);
    #1 {cmd_rd, cmd_code} = {1'h0, ~code};
    for (n = 0; n < 4 && cmd_rvalid !== 1'h1; n++) @(posedge clk_sys) #1;
    ok = (cmd_rvalid === 1'h1);
    data = cmd_rdata;
  endtask
endmodule

/* dv/tb.sv */
// Purpose: self-checking bench for the mask and status bank
// Assumes: the host model owns the command port strobes
// Notes:   one source at a time, so each mask bit is seen alone
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin n_fail++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, a, b); end end
module tb
  import famsr_pkg::*;
;
  logic clk_sys = 1'h0, rst_b = 1'h0, device_ready, supply_ok_flag;
  logic phase2_enabled, phase3_enabled, phase4_enabled, power_save_input;
  logic cmd_wr, cmd_rd, cmd_rvalid, warning_pin_o, warning_pin_oe_b, trip_pin_o, trip_pin_oe_b;
  logic [7:0] cmd_code, cmd_wdata, cmd_rdata, warning_mask_out, trip_mask_out, d;
  logic [4:0] src;
  logic       ok;
  wire vout_status_any, iout_status_any, comm_logic_status, monitored_voltage, pout_over_limit;
  int n_fail = 0, samples_checked = 0;
  int bits[5] = '{7, 6, 3, 2, 0};
  assign {vout_status_any, iout_status_any, comm_logic_status, monitored_voltage,
          pout_over_limit} = src;
  always #10 clk_sys = ~clk_sys;
  famsr_top u_dut (.*);
  famsr_host u_host (.*);
  task automatic give_verdict();
    $display("checks=%0d mismatches=%0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic rdc(input logic [7:0] code, input logic [7:0] exp);
    u_host.rd(code, d, ok);
    if (!ok) begin
      n_fail++;
      give_verdict();
    end
    `CHK(d, exp)
  endtask
  initial begin
    src = 5'h00;
    {device_ready, supply_ok_flag} = 2'h1;
    {phase4_enabled, phase3_enabled, phase2_enabled, power_save_input} = 4'h0;
    repeat (2) @(posedge clk_sys);
    #1 rst_b = 1'h1;
    repeat (3) @(posedge clk_sys);
    #1;
    `CHK({warning_pin_o, trip_pin_o, warning_pin_oe_b, trip_pin_oe_b, warning_mask_out, trip_mask_out}, 20'h30000)
    rdc(FAMSR_WARN_MASK_CMD, FAMSR_WARN_MASK_RST);
    rdc(FAMSR_TRIP_MASK_CMD, FAMSR_TRIP_MASK_RST);
    // reserved mask bits must read back as zero
    u_host.wr(FAMSR_WARN_MASK_CMD, 8'hFF);
    rdc(FAMSR_WARN_MASK_CMD, FAMSR_MASK_WMASK);
    u_host.wr(FAMSR_TRIP_MASK_CMD, 8'hFF);
    rdc(FAMSR_TRIP_MASK_CMD, FAMSR_MASK_WMASK);
    u_host.wr(FAMSR_SUMMARY_CMD, 8'hFF);
    rdc(FAMSR_SUMMARY_CMD, 8'h00);
    rdc(8'h10, FAMSR_UNMAPPED_DATA);
    u_host.wr(FAMSR_WARN_MASK_CMD, 8'h00);
    u_host.wr(FAMSR_TRIP_MASK_CMD, 8'h00);
    device_ready = 1'h1;
    for (int i = 0; i < 5; i++) begin
      src = 5'h10 >> i;
      repeat (4) @(posedge clk_sys);
      #1;
      `CHK({warning_pin_oe_b, trip_pin_oe_b}, 2'h0)
      u_host.wr(FAMSR_WARN_MASK_CMD, 8'h01 << bits[i]);
      rdc(FAMSR_SUMMARY_CMD, 8'h90);
      `CHK({warning_pin_oe_b, trip_pin_oe_b}, 2'h2)
      u_host.wr(FAMSR_TRIP_MASK_CMD, 8'h01 << bits[i]);
      repeat (3) @(posedge clk_sys);
      #1;
      `CHK({warning_pin_oe_b, trip_pin_oe_b, trip_mask_out}, {2'h3, 8'h01 << bits[i]})
      u_host.wr(FAMSR_WARN_MASK_CMD, 8'h00);
      u_host.wr(FAMSR_TRIP_MASK_CMD, 8'h00);
      src = 5'h00;
    end
    for (int p = 0; p < 16; p++) begin
      {phase4_enabled, phase3_enabled, phase2_enabled, power_save_input} = p[3:0];
      rdc(FAMSR_PHASE_CMD, {2'h0, p[3:0], 2'h0});
    end
    give_verdict();
  end
endmodule
